// *** design/pcrw_glitch_filter.v ***
// Synchroniser and glitch filter for the external reset pin
`timescale 1ns/100ps
`include "pcrw_map.vh"

module pcrw_glitch_filter (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_pin_n,
  output reg  o_level
);

  reg  [1:0] sync_reg;
  reg  [2:0] stable_reg;

  // Last filter count, cut to the counter width on purpose
  localparam [31:0] FILT_LAST = `PCRW_FILT_CYCLES - 1;

  // ======================================================================
  // Two-stage synchroniser; only stage two is looked at
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= {sync_reg[0], i_pin_n};
    end
  end

  // ======================================================================
  // Level must stand for the filter time before it is passed on
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stable_reg <= 3'h0;
      o_level    <= 1'b0;
    end else if (sync_reg[1] == o_level) begin
      stable_reg <= 3'h0;
    end else if (stable_reg == FILT_LAST[2:0]) begin
      stable_reg <= 3'h0;
      o_level    <= sync_reg[1];
    end else begin
      stable_reg <= stable_reg + 3'h1;
    end
  end

endmodule // pcrw_glitch_filter

// *** design/pcrw_outdiv.v ***
// Output divider of the multiplied clock, divide by 2, 4, 8 or 16
`timescale 1ns/100ps

module pcrw_outdiv (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_run,
  input  wire       i_tick,
  input  wire [1:0] i_psel,
  output reg        o_div_clk,
  output reg        o_boundary
);

  reg  [2:0] cnt_reg;
  wire [2:0] half_m1;

  // Half period in oscillator edges minus one: 1, 2, 4, 8 edges
  assign half_m1 = (3'h1 << i_psel) - 3'h1;

  // ======================================================================
  // Toggle on equal half periods, so the duty is always one half
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg    <= 3'h0;
      o_div_clk  <= 1'b0;
      o_boundary <= 1'b0;
    end else if (!i_run) begin
      cnt_reg    <= 3'h0;
      o_div_clk  <= 1'b0;
      o_boundary <= 1'b0;
    end else if (i_tick && cnt_reg == half_m1) begin
      cnt_reg    <= 3'h0;
      o_div_clk  <= ~o_div_clk;
      o_boundary <= ~o_div_clk; // Marks the end of a whole low phase
    end else begin
      cnt_reg    <= i_tick ? cnt_reg + 3'h1 : cnt_reg;
      o_boundary <= 1'b0;
    end
  end

endmodule // pcrw_outdiv

// *** design/pcrw_top.v ***
// Clock multiplier control, reset sequencer and wake-up timer with APB registers
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "pcrw_map.vh"

module pcrw_top #(
  parameter integer OSC_MHZ     = 12,
  parameter integer LOCK_CYCLES = `PCRW_LOCK_CYCLES,
  parameter integer WAKE_CLKS   = `PCRW_WAKE_CLKS
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_reset_pin_n,
  input  wire        i_wdt_timeout,
  input  wire        i_osc_running,
  input  wire        i_flash_init_done,
  input  wire        i_wake_event,
  input  wire        i_cco_clk,
  output reg         o_int_rst_n,
  output reg         o_core_run,
  output reg         o_osc_en,
  output reg         o_flash_init_start,
  output reg         o_pll_power,
  output reg  [4:0]  o_pll_msel,
  output reg  [1:0]  o_pll_psel,
  output reg         o_pll_locked,
  output reg         o_core_clk_pll,
  output wire        o_pll_div_clk,
  output reg         o_vector_sram,
  output reg  [31:0] o_reset_vector
);

  // ======================================================================
  // Sequencer states
  localparam [5:0] S_HOLD  = 6'h01;
  localparam [5:0] S_OSC   = 6'h02;
  localparam [5:0] S_COUNT = 6'h04;
  localparam [5:0] S_FLASH = 6'h08;
  localparam [5:0] S_RUN   = 6'h10;
  localparam [5:0] S_PDOWN = 6'h20;

  // Last count of each timer; the counters take only the low bits
  localparam [31:0] WAKE_LAST = WAKE_CLKS - 1;
  localparam [31:0] LOCK_LAST = LOCK_CYCLES - 1;

  // ======================================================================
  // Multiplier limits check, used for the live setting only
  function cfg_ok_f;
    input [4:0] msel;
    input [1:0] psel;
    integer     mult;
    integer     fout;
    integer     fcco;
    begin
      mult     = msel + 1;
      fout     = OSC_MHZ * mult;
      fcco     = fout * (2 << psel);
      cfg_ok_f = (OSC_MHZ >= `PCRW_IN_MIN_MHZ) && (OSC_MHZ <= `PCRW_IN_MAX_MHZ) &&
                 (fout >= `PCRW_OUT_MIN_MHZ) && (fout <= `PCRW_OUT_MAX_MHZ) &&
                 (fcco >= `PCRW_CCO_MIN_MHZ) && (fcco <= `PCRW_CCO_MAX_MHZ);
    end
  endfunction

  // ======================================================================
  // Declarations
  reg  [1:0]  osc_sync_reg;
  reg  [1:0]  wake_sync_reg;
  reg  [2:0]  cco_sync_reg;
  reg  [5:0]  state_reg;
  reg  [5:0]  state_next;
  reg  [12:0] wake_cnt_reg;
  reg         boot_reg;
  reg         pll_en_reg;
  reg         pll_conn_reg;
  reg         pdown_req_reg;
  reg  [12:0] lock_cnt_reg;
  reg  [31:0] rdata_next;
  wire        pin_level;
  wire        osc_ok;
  wire        wake_ok;
  wire        cco_tick;
  wire        reset_src;
  wire        chip_rst;
  wire        cfg_ok;
  wire        lock_run;
  wire        want_pll;
  wire        div_boundary;
  wire        setup_acc;
  wire        bus_acc;
  wire        wr_acc;
  wire        mapped;
  wire        cfg_wr;

  // ======================================================================
  // Reset pin filter
  pcrw_glitch_filter u_filter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin_n (i_reset_pin_n),
    .o_level (pin_level)
  );

  // ======================================================================
  // Synchronisers for the analog status, wake event and oscillator pins
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_sync_reg  <= 2'h0;
      wake_sync_reg <= 2'h0;
      cco_sync_reg  <= 3'h0;
    end else begin
      osc_sync_reg  <= {osc_sync_reg[0], i_osc_running};
      wake_sync_reg <= {wake_sync_reg[0], i_wake_event};
      cco_sync_reg  <= {cco_sync_reg[1:0], i_cco_clk};
    end
  end

  assign osc_ok   = osc_sync_reg[1];
  assign wake_ok  = wake_sync_reg[1];
  // Edge taken between stage two and three; the oscillator must run below half of i_clk
  assign cco_tick = cco_sync_reg[1] & ~cco_sync_reg[2];

  // Only the filtered pin and the watchdog can reset the chip
  assign reset_src = ~pin_level | i_wdt_timeout;
  assign chip_rst  = ~o_int_rst_n;

  // ======================================================================
  // Sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_HOLD: begin
        state_next = S_OSC;
      end
      S_OSC: begin
        if (osc_ok) begin
          state_next = S_COUNT;
        end
      end
      S_COUNT: begin
        if (!osc_ok) begin
          state_next = S_OSC;
        end else if (wake_cnt_reg == WAKE_LAST[12:0]) begin
          state_next = boot_reg ? S_FLASH : S_RUN;
        end
      end
      S_FLASH: begin
        // Ready seen while the start pulse stands is stale from the last run
        if (i_flash_init_done && !o_flash_init_start) begin
          state_next = S_RUN;
        end
      end
      S_RUN: begin
        if (!osc_ok) begin
          state_next = S_OSC;
        end else if (pdown_req_reg) begin
          state_next = S_PDOWN;
        end
      end
      S_PDOWN: begin
        if (wake_ok) begin
          state_next = S_OSC;
        end
      end
      default: begin
        state_next = S_HOLD;
      end
    endcase
    if (reset_src) begin
      state_next = S_HOLD;
    end
  end

  // ======================================================================
  // Sequencer registers and wake-up timer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg          <= S_HOLD;
      wake_cnt_reg       <= 13'h0000;
      boot_reg           <= 1'b1;
      o_int_rst_n        <= 1'b0;
      o_core_run         <= 1'b0;
      o_osc_en           <= 1'b1;
      o_flash_init_start <= 1'b0;
    end else begin
      state_reg          <= state_next;
      o_flash_init_start <= (state_reg == S_COUNT) && (state_next == S_FLASH);
      // Count restarts whenever the counting state is entered afresh
      if (state_reg != S_COUNT || state_next != S_COUNT) begin
        wake_cnt_reg <= 13'h0000;
      end else begin
        wake_cnt_reg <= wake_cnt_reg + 13'h0001;
      end
      if (state_next == S_HOLD) begin
        boot_reg    <= 1'b1;
        o_int_rst_n <= 1'b0;
      end else if (state_next == S_RUN && state_reg != S_RUN) begin
        boot_reg    <= 1'b0;
        o_int_rst_n <= 1'b1;
      end
      // Execution only in the run state; the oscillator is off only in power-down
      o_core_run <= (state_next == S_RUN);
      o_osc_en   <= (state_next != S_PDOWN);
    end
  end

  // ======================================================================
  // APB decode; one wait state, so every access answers on its second cycle
  assign setup_acc = i_psel & i_penable & ~o_pready;
  assign bus_acc   = i_psel & i_penable & o_pready;
  assign wr_acc    = bus_acc & i_pwrite & mapped & ~chip_rst;
  assign mapped    = (i_paddr == `PCRW_OFS_CTRL) || (i_paddr == `PCRW_OFS_CFG) ||
                     (i_paddr == `PCRW_OFS_STAT) || (i_paddr == `PCRW_OFS_REMAP) ||
                     (i_paddr == `PCRW_OFS_PWR);
  assign cfg_wr    = wr_acc && (i_paddr == `PCRW_OFS_CFG);
  assign cfg_ok    = cfg_ok_f(o_pll_msel, o_pll_psel);

  // Read data multiplexer
  always @* begin
    rdata_next = 32'h00000000;
    case (i_paddr)
      `PCRW_OFS_CTRL: begin
        rdata_next[`PCRW_CTRL_EN]   = pll_en_reg;
        rdata_next[`PCRW_CTRL_CONN] = pll_conn_reg;
      end
      `PCRW_OFS_CFG: begin
        rdata_next[`PCRW_CFG_MSEL_MSB:`PCRW_CFG_MSEL_LSB] = o_pll_msel;
        rdata_next[`PCRW_CFG_PSEL_MSB:`PCRW_CFG_PSEL_LSB] = o_pll_psel;
      end
      `PCRW_OFS_STAT: begin
        rdata_next[`PCRW_STAT_LOCK]   = o_pll_locked;
        rdata_next[`PCRW_STAT_SEL]    = o_core_clk_pll;
        rdata_next[`PCRW_STAT_CFG_OK] = cfg_ok;
        rdata_next[13:8]              = state_reg;
      end
      `PCRW_OFS_REMAP: begin
        rdata_next[`PCRW_REMAP_SRAM] = o_vector_sram;
      end
      `PCRW_OFS_PWR: begin
        rdata_next[`PCRW_PWR_PDOWN] = pdown_req_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // ======================================================================
  // Bus answer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= setup_acc;
      o_pslverr <= setup_acc & ~mapped;
      o_prdata  <= setup_acc ? rdata_next : 32'h00000000;
    end
  end

  // ======================================================================
  // Software registers; chip reset forces every one back to its reset value
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_en_reg     <= 1'b0;
      pll_conn_reg   <= 1'b0;
      o_pll_msel     <= `PCRW_RST_MSEL;
      o_pll_psel     <= `PCRW_RST_PSEL;
      o_vector_sram  <= `PCRW_RST_REMAP;
      pdown_req_reg  <= 1'b0;
      o_reset_vector <= `PCRW_RESET_VECTOR;
    end else if (chip_rst) begin
      pll_en_reg     <= 1'b0;
      pll_conn_reg   <= 1'b0;
      o_pll_msel     <= `PCRW_RST_MSEL;
      o_pll_psel     <= `PCRW_RST_PSEL;
      o_vector_sram  <= `PCRW_RST_REMAP;
      pdown_req_reg  <= 1'b0;
      o_reset_vector <= `PCRW_RESET_VECTOR;
    end else begin
      if (wr_acc && i_paddr == `PCRW_OFS_CTRL) begin
        pll_en_reg   <= i_pwdata[`PCRW_CTRL_EN];
        pll_conn_reg <= i_pwdata[`PCRW_CTRL_CONN];
      end
      if (cfg_wr) begin
        // 5-bit field holds factor minus one, so only 1..32 exist
        o_pll_msel <= i_pwdata[`PCRW_CFG_MSEL_MSB:`PCRW_CFG_MSEL_LSB];
        o_pll_psel <= i_pwdata[`PCRW_CFG_PSEL_MSB:`PCRW_CFG_PSEL_LSB];
      end
      if (wr_acc && i_paddr == `PCRW_OFS_REMAP) begin
        o_vector_sram <= i_pwdata[`PCRW_REMAP_SRAM];
      end
      // Request set by software, dropped once power-down is entered
      if (wr_acc && i_paddr == `PCRW_OFS_PWR && i_pwdata[`PCRW_PWR_PDOWN]) begin
        pdown_req_reg <= 1'b1;
      end else if (state_reg == S_PDOWN) begin
        pdown_req_reg <= 1'b0;
      end
    end
  end

  // ======================================================================
  // Multiplier power and lock timer; a settings write restarts locking
  assign lock_run = o_pll_power & cfg_ok & osc_ok;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pll_power  <= 1'b0;
      lock_cnt_reg <= 13'h0000;
      o_pll_locked <= 1'b0;
    end else begin
      // No power while in reset or power-down
      o_pll_power <= pll_en_reg & ~chip_rst & (state_reg != S_PDOWN);
      if (!lock_run || cfg_wr || chip_rst) begin
        lock_cnt_reg <= 13'h0000;
        o_pll_locked <= 1'b0;
      end else if (lock_cnt_reg == LOCK_LAST[12:0]) begin
        o_pll_locked <= 1'b1;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + 13'h0001;
      end
    end
  end

  // ======================================================================
  // Output divider of the multiplied clock
  pcrw_outdiv u_outdiv (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (o_pll_power),
    .i_tick     (cco_tick),
    .i_psel     (o_pll_psel),
    .o_div_clk  (o_pll_div_clk),
    .o_boundary (div_boundary)
  );

  // ======================================================================
  // Core clock source; connect is honoured only once locked
  assign want_pll = pll_conn_reg & o_pll_power & o_pll_locked;

  // Switch only at the end of a full low phase of the divided clock, so
  // neither source is cut short. An unpowered multiplier gives no boundary,
  // so falling back to the oscillator then happens at once.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_clk_pll <= 1'b0;
    end else if (chip_rst || !o_pll_power) begin
      o_core_clk_pll <= 1'b0;
    end else if (div_boundary) begin
      o_core_clk_pll <= want_pll;
    end
  end

endmodule // pcrw_top

// *** include/pcrw_map.vh ***
// Register map, field positions, reset values and timing for the clock and reset block
`ifndef PCRW_MAP_VH
`define PCRW_MAP_VH

// ======================================================================
// Register offsets (byte addresses)
`define PCRW_OFS_CTRL      12'h000
`define PCRW_OFS_CFG       12'h004
`define PCRW_OFS_STAT      12'h008
`define PCRW_OFS_REMAP     12'h00C
`define PCRW_OFS_PWR       12'h010

// ======================================================================
// Field positions
`define PCRW_CTRL_EN       0
`define PCRW_CTRL_CONN     1
`define PCRW_CFG_MSEL_LSB  0
`define PCRW_CFG_MSEL_MSB  4
`define PCRW_CFG_PSEL_LSB  5
`define PCRW_CFG_PSEL_MSB  6
`define PCRW_STAT_LOCK     0
`define PCRW_STAT_SEL      1
`define PCRW_STAT_CFG_OK   2
`define PCRW_REMAP_SRAM    0
`define PCRW_PWR_PDOWN     0

// ======================================================================
// Reset values
`define PCRW_RST_CTRL      2'h0
`define PCRW_RST_MSEL      5'h00
`define PCRW_RST_PSEL      2'h0
`define PCRW_RST_REMAP     1'h0
`define PCRW_RESET_VECTOR  32'h00000000

// ======================================================================
// Frequency limits in MHz and the software multiplier limit
`define PCRW_IN_MIN_MHZ    10
`define PCRW_IN_MAX_MHZ    25
`define PCRW_OUT_MIN_MHZ   10
`define PCRW_OUT_MAX_MHZ   60
`define PCRW_CCO_MIN_MHZ   156
`define PCRW_CCO_MAX_MHZ   320
`define PCRW_SW_MULT_MAX   6

// ======================================================================
// Timing
`define PCRW_CLK_MHZ       50
`define PCRW_LOCK_US       100
`define PCRW_LOCK_CYCLES   (`PCRW_LOCK_US * `PCRW_CLK_MHZ)
`define PCRW_WAKE_CLKS     4096
`define PCRW_FILT_CYCLES   4

`endif

// *** tb/pcrw_far_side_model.sv ***
// Behavioural oscillator, multiplied clock and flash controller
`timescale 1ns/100ps

module pcrw_far_side_model #(
  parameter int FLASH_CYCLES = 5
) (
  input  wire logic i_clk,
  input  wire logic i_osc_en,
  input  wire logic i_osc_kill,
  input  wire logic i_flash_init_start,
  output logic      o_osc_running = 1'b0,
  output logic      o_flash_init_done = 1'b0,
  output logic      o_cco_clk = 1'b0
);
  int up_cnt = 0;
  int fl_cnt = 0;
  int cc_cnt = 0;

  // Oscillator needs five cycles to start; kill models a lost crystal
  always @(posedge i_clk) begin
    if (!i_osc_en || i_osc_kill) up_cnt <= 0;
    else if (up_cnt < 4) up_cnt <= up_cnt + 1;
    o_osc_running <= (up_cnt == 4) && i_osc_en && !i_osc_kill;
  end

  // Slow square wave, stands still while the oscillator is off
  always @(posedge i_clk) begin
    if (o_osc_running) begin
      cc_cnt <= (cc_cnt == 2) ? 0 : cc_cnt + 1;
      if (cc_cnt == 2) o_cco_clk <= ~o_cco_clk;
    end
  end

  // Flash ready drops at each start and returns after a delay
  always @(posedge i_clk) begin
    if (i_flash_init_start) begin
      fl_cnt <= FLASH_CYCLES;
      o_flash_init_done <= 1'b0;
    end else if (fl_cnt == 1) begin
      fl_cnt <= 0;
      o_flash_init_done <= 1'b1;
    end else if (fl_cnt > 1) fl_cnt <= fl_cnt - 1;
  end
endmodule // pcrw_far_side_model

// *** tb/pcrw_top_bench.sv ***
// Self-checking testbench of the clock and reset block
`timescale 1ns/100ps

module pcrw_top_bench;
  localparam int LC = 20;
  localparam int WC = 8;
  localparam int FC = 5;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pin_n = 1, wdt = 0, wake = 0, kill = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic e;
  int error_cnt = 0, checks_done = 0, n, hi, lo;
  wire [31:0] o_prdata, o_reset_vector;
  wire [4:0] o_pll_msel;
  wire [1:0] o_pll_psel;
  wire o_pready, o_pslverr, osc_ok, fl_done, current_controlled_oscillator, o_int_rst_n, o_core_run, o_osc_en, fl_start;
  wire o_pll_power, o_pll_locked, o_core_clk_pll, o_pll_div_clk, o_vector_sram;

  always #10 clk = ~clk;

  pcrw_top #(.OSC_MHZ(12), .LOCK_CYCLES(LC), .WAKE_CLKS(WC)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_reset_pin_n(pin_n), .i_wdt_timeout(wdt),
    .i_osc_running(osc_ok), .i_flash_init_done(fl_done), .i_wake_event(wake),
    .i_cco_clk(current_controlled_oscillator), .o_int_rst_n(o_int_rst_n), .o_core_run(o_core_run), .o_osc_en(o_osc_en),
    .o_flash_init_start(fl_start), .o_pll_power(o_pll_power), .o_pll_msel(o_pll_msel),
    .o_pll_psel(o_pll_psel), .o_pll_locked(o_pll_locked), .o_core_clk_pll(o_core_clk_pll),
    .o_pll_div_clk(o_pll_div_clk), .o_vector_sram(o_vector_sram),
    .o_reset_vector(o_reset_vector));

  pcrw_far_side_model #(.FLASH_CYCLES(FC)) i_far (.i_clk(clk), .i_osc_en(o_osc_en),
    .i_osc_kill(kill), .i_flash_init_start(fl_start), .o_osc_running(osc_ok),
    .o_flash_init_done(fl_done), .o_cco_clk(current_controlled_oscillator));

  // ==========================================================
  // Shared tasks
  task test_done;
    $display("Counts: %0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tmo(input int k);
    error_cnt++;
    $display("Error wait %0d expected done seen timeout", k);
    test_done();
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return o_core_run;
      1: return o_pll_locked;
      2: return o_core_clk_pll;
      3: return o_int_rst_n;
      default: return o_osc_en;
    endcase
  endfunction

  // Bounded wait for an output to reach a level; n returns cycles used
  task wsig(input int k, input logic v, input int lim, output int c);
    for (c = 0; sig(k) !== v; c++) begin
      if (c == lim) tmo(k);
      @(posedge clk);
    end
  endtask

  // One APB transfer; idle cycle after it so the write has landed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int c;
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (o_pready !== 1'b1 && c < 20);
    q = o_prdata;
    e = o_pslverr;
    psel <= 0;
    pen <= 0;
    if (c == 20) tmo(9);
    @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    wsig(0, 1, 200, n);
    apb(0, 12'h000, 0); chk("ctrl", 0, q);
    apb(0, 12'h004, 0); chk("cfg", 0, q);
    apb(0, 12'h00C, 0); chk("remap", 0, q);
    apb(0, 12'h008, 0); chk("stat", 32'h1000, q);
    chk("vector", 0, o_reset_vector);
    apb(0, 12'h014, 0); chk("unmapped err", 1, e);
    $display("reset test done");
  endtask

  task t_pll;
    apb(1, 12'h004, 32'h24); apb(0, 12'h008, 0); chk("cfg ok", 1, q[2]);
    apb(1, 12'h000, 1); wsig(1, 1, 100, n);
    chk("lock time", 1, n >= LC - 4 && n <= LC + 5);
    chk("still bypassed", 0, o_core_clk_pll);
    apb(1, 12'h000, 3); wsig(2, 1, 100, n);
    chk("factor", 4, o_pll_msel);
    apb(0, 12'h008, 0); chk("stat sel", 3, q[1:0]);
    for (int p = 0; p < 4; p++) begin
      apb(1, 12'h004, 32'h4 | (p << 5)); chk("psel", p, o_pll_psel);
      for (n = 0; o_pll_div_clk !== 1'b0 && n < 300; n++) @(posedge clk);
      for (n = 0; o_pll_div_clk !== 1'b1 && n < 300; n++) @(posedge clk);
      for (hi = 0; o_pll_div_clk === 1'b1 && hi < 300; hi++) @(posedge clk);
      for (lo = 0; o_pll_div_clk === 1'b0 && lo < 300; lo++) @(posedge clk);
      if (n == 300 || hi == 300 || lo == 300) tmo(5);
      chk("duty", hi, lo);
      chk("divide", 1, hi >= (6 << p) - 1 && hi <= (6 << p) + 1);
    end
    apb(1, 12'h004, 32'h1F); apb(0, 12'h008, 0); chk("cfg bad", 0, q[2]);
    repeat (40) @(posedge clk);
    chk("no lock", 0, o_pll_locked);
    chk("back to osc", 0, o_core_clk_pll);
    apb(1, 12'h000, 0); @(posedge clk); chk("power off", 0, o_pll_power);
    $display("multiplier test done");
  endtask

  task t_remap;
    apb(1, 12'h00C, 1); chk("sram", 1, o_vector_sram);
    apb(0, 12'h00C, 0); chk("remap read", 1, q);
    apb(1, 12'h00C, 0); chk("flash", 0, o_vector_sram);
    $display("remap test done");
  endtask

  task t_wdt;
    apb(1, 12'h004, 32'h24); apb(1, 12'h000, 1); apb(1, 12'h00C, 1);
    wdt <= 1;
    @(posedge clk);
    wdt <= 0;
    wsig(3, 0, 5, n);
    wsig(0, 1, 200, n); chk("wake count", 1, n >= WC + FC);
    chk("power", 0, o_pll_power);
    chk("remap", 0, o_vector_sram);
    apb(0, 12'h000, 0); chk("ctrl", 0, q);
    $display("watchdog test done");
  endtask

  task t_pin;
    pin_n <= 0;
    @(posedge clk);
    pin_n <= 1;
    repeat (10) @(posedge clk);
    chk("glitch", 1, o_int_rst_n);
    pin_n <= 0;
    repeat (12) @(posedge clk);
    chk("pin reset", 0, o_int_rst_n);
    pin_n <= 1;
    wsig(0, 1, 200, n); chk("wake count", 1, n >= WC + FC + 6);
    $display("reset pin test done");
  endtask

  task t_pdown;
    apb(1, 12'h010, 1); wsig(4, 0, 10, n);
    repeat (10) @(posedge clk);
    chk("halted", 0, o_core_run);
    wake <= 1;
    wsig(0, 1, 200, n); chk("wake count", 1, n >= WC);
    wake <= 0;
    chk("no reset", 1, o_int_rst_n);
    $display("power-down test done");
  endtask

  task t_osc;
    kill <= 1;
    wsig(0, 0, 10, n);
    kill <= 0;
    wsig(0, 1, 200, n); chk("wake count", 1, n >= WC);
    chk("no reset", 1, o_int_rst_n);
    $display("oscillator loss test done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_reset();
    t_pll();
    t_remap();
    t_wdt();
    t_pin();
    t_pdown();
    t_osc();
    test_done();
  end
endmodule // pcrw_top_bench

// *** tb/pcrw_top_properties.sv ***
// Concurrent checks on the ports of the clock and reset block
`timescale 1ns/100ps

module pcrw_top_checker #(
  parameter integer LOCK_CYCLES = 20
) (
  input logic        i_clk,
  input logic        i_rst_n,
  input logic        i_psel,
  input logic        i_penable,
  input logic        o_pready,
  input logic        i_reset_pin_n,
  input logic        i_wdt_timeout,
  input logic        i_osc_running,
  input logic        o_int_rst_n,
  input logic        o_core_run,
  input logic        o_osc_en,
  input logic        o_pll_power,
  input logic        o_pll_locked,
  input logic        o_core_clk_pll,
  input logic        o_pll_div_clk,
  input logic        o_vector_sram,
  input logic [31:0] o_reset_vector
);
  int unsigned pwr_cnt;

  // Consecutive powered cycles, saturating so it never wraps
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) pwr_cnt <= 0;
    else if (!o_pll_power) pwr_cnt <= 0;
    else if (pwr_cnt < 4095) pwr_cnt <= pwr_cnt + 1;
  end

  // ==========================================================
  // Sequences and properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_glitch;
    o_int_rst_n && i_reset_pin_n ##1 !i_reset_pin_n ##1 i_reset_pin_n [*6];
  endsequence

  a_ready_pulse: assert property (s_access |=> o_pready ##1 !o_pready)
    else $error("ready not a single pulse after access");
  a_glitch_ignored: assert property (s_glitch |-> o_int_rst_n)
    else $error("short pin glitch reset the chip");
  a_pin_resets: assert property (!i_reset_pin_n [*8] |=> !o_int_rst_n)
    else $error("held reset pin did not reset");
  a_wdt_resets: assert property (i_wdt_timeout |-> ##[1:3] !o_int_rst_n)
    else $error("watchdog timeout did not reset");
  a_release_conds: assert property ($rose(o_int_rst_n) |->
    i_reset_pin_n && i_osc_running && o_reset_vector == 32'h0)
    else $error("reset released without its conditions");
  a_bypass_reset: assert property (!o_int_rst_n [*3] |->
    !o_pll_power && !o_core_clk_pll && !o_vector_sram)
    else $error("multiplier or remap active in reset");
  a_sel_needs_lock: assert property ($rose(o_core_clk_pll) |->
    o_pll_locked && o_pll_power)
    else $error("clock source switched without lock");
  a_lock_time: assert property ($rose(o_pll_locked) |-> pwr_cnt >= LOCK_CYCLES - 2)
    else $error("lock too early after power");
  a_div_idle: assert property (!o_pll_power [*3] |-> !o_pll_div_clk)
    else $error("divided clock runs unpowered");
  a_osc_loss: assert property (!i_osc_running [*5] |-> !o_core_run)
    else $error("core runs without oscillator");
  a_pdown_stop: assert property (!o_osc_en [*2] |-> !o_core_run && !o_pll_power)
    else $error("core or multiplier on in power-down");
endmodule // pcrw_top_checker

bind pcrw_top pcrw_top_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .i_clk, .i_rst_n, .i_psel, .i_penable, .o_pready, .i_reset_pin_n, .i_wdt_timeout,
  .i_osc_running, .o_int_rst_n, .o_core_run, .o_osc_en, .o_pll_power, .o_pll_locked,
  .o_core_clk_pll, .o_pll_div_clk, .o_vector_sram, .o_reset_vector
);
